// ### rtl/amcs_pkg.sv
/*
  amcs_pkg: constants, encodings and carrier types of the converter
  mode and conversion sequencer.
  assumes: one 40 MHz system clock; the serial pins arrive unsynchronised.
*/
package amcs_pkg;

  // system clock and internal conversion clock rates
  localparam int SYS_FREQ_KHZ      = 40000;
  localparam int ICLK_FREQ_KHZ     = 4500;
  localparam int ICLK_DIV          = SYS_FREQ_KHZ / ICLK_FREQ_KHZ;
  // internal clock start window after the arming edge, least time used
  localparam int ICLK_START_MIN_NS = 100;
  localparam int ICLK_START_MAX_NS = 400;
  localparam int ICLK_START_CYC    = (ICLK_START_MIN_NS * SYS_FREQ_KHZ + 999_999) / 1_000_000;

  // data widths
  localparam int RES_W             = 16;
  localparam int BYTE_W            = 8;
  localparam int N_CH              = 8;

  // control byte field positions
  localparam int START_POS         = 7;
  localparam int CODE_HI           = 6;
  localparam int CODE_LO           = 4;
  localparam int TAG_HI            = 3;
  localparam int TAG_LO            = 0;

  // low nibble that marks the byte type
  localparam logic [3:0] TAG_MODE      = 4'h8;
  localparam logic [3:0] TAG_CONV      = 4'h0;
  // channel range after reset: single-ended bipolar full reference
  localparam logic [3:0] RANGE_DEFAULT = 4'h7;
  // receive shift seed, its top bit marks a complete byte
  localparam logic [7:0] RX_SEED       = 8'h01;

  // serial clock fall counts from the start bit, and the internal clock tick count of the sample
  localparam logic [4:0] SAMPLE_FALL_EXTCLK = 5'd14;
  localparam logic [4:0] SAMPLE_FALL_EXTACQ = 5'd16;
  localparam logic [4:0] ARM_FALL_ICLK      = 5'd8;
  localparam logic [3:0] SAMPLE_TICK_ICLK   = 4'd11;

  // result bits that must be out before a new start bit is heard
  localparam logic [4:0] READ_MIN_EXTCLK = 5'd13;
  localparam logic [4:0] READ_MIN_EXTACQ = 5'd9;
  localparam logic [4:0] READ_MIN_ICLK   = 5'd12;

  // operating mode codes
  typedef enum logic [2:0]
  {
    MODE_EXTCLK = 3'b000,
    MODE_EXTACQ = 3'b001,
    MODE_ICLK   = 3'b010,
    MODE_RSV3   = 3'b011,
    MODE_RESET  = 3'b100,
    MODE_RSV5   = 3'b101,
    MODE_PPD    = 3'b110,
    MODE_FPD    = 3'b111
  } amcs_mode_e;

  // analog power state
  typedef enum logic [1:0]
  {
    PWR_FULL    = 2'b00,
    PWR_PARTIAL = 2'b01,
    PWR_OFF     = 2'b10
  } amcs_pwr_e;

  // sequencer states, one-hot
  typedef enum logic [5:0]
  {
    ST_IDLE  = 6'b000001,
    ST_CMD   = 6'b000010,
    ST_ACQ   = 6'b000100,
    ST_DELAY = 6'b001000,
    ST_ICLK  = 6'b010000,
    ST_CONV  = 6'b100000
  } amcs_state_e;

  // serial pins from the host
  typedef struct packed
  {
    logic cs_n;
    logic sclk;
    logic din;
  } amcs_pins_s;

endpackage

// ### rtl/amcs_sequencer.sv
/*
  amcs_sequencer: serial control byte receiver, mode and power state,
  sample and conversion timing, result buffer and serial result shifter.
  assumes: pins are asynchronous to sys_clk_i and sclk is far slower than
  it; the successive-approximation core steps on conv_step_o and hands
  back each result with valid/ready.
*/
`timescale 1ns/100ps
`default_nettype none

module amcs_sequencer
#(
  parameter int N_CH_P  = 8,
  parameter int RES_W_P = 16
)
(
  input  wire logic                sys_clk_i,
  input  wire logic                arst_n_i,
  input  wire amcs_pkg::amcs_pins_s pins_i,
  output logic                     dout_o,
  output logic                     dout_oe_o,
  output logic                     conversion_done_strobe_o,
  output logic                     sample_o,
  output logic                     conv_step_o,
  output logic [2:0]               channel_o,
  output logic [3:0]               range_o,
  output amcs_pkg::amcs_mode_e     mode_o,
  output amcs_pkg::amcs_pwr_e      power_o,
  input  wire logic [15:0]         result_data_i,
  input  wire logic                result_valid_i,
  output logic                     result_ready_o
);
  import amcs_pkg::*;

  // the byte fields and read counts fix both figures
  if (N_CH_P != N_CH || RES_W_P != RES_W)
  begin : g_bad_param
    $error("amcs_sequencer: channel count and result width are fixed");
  end

  // pin synchroniser stages and edge history
  amcs_pins_s  sync1_reg;                    // first stage, read by stage two only
  amcs_pins_s  sync2_reg;                    // safe copy
  amcs_pins_s  sync3_reg;                    // previous safe copy
  logic        sclk_rise;                    // serial clock rising edge
  logic        sclk_fall;                    // serial clock falling edge
  logic        cs_low;                       // chip select asserted

  // sequencer state
  amcs_state_e state_reg;                    // current state
  amcs_state_e state_next;                   // next state
  logic [7:0]  rx_reg;                       // received byte with seed marker
  logic [4:0]  fall_cnt_reg;                 // falling edges since start bit
  logic [3:0]  tick_cnt_reg;                 // internal clock ticks
  logic [4:0]  dly_cnt_reg;                  // internal clock start delay
  logic [3:0]  div_cnt_reg;                  // internal clock divider
  logic        iclk_tick;                    // internal clock falling edge
  logic        byte_done;                    // full control byte held
  logic [3:0]  rx_tag;                       // low nibble of byte
  amcs_mode_e  rx_code;                      // mode or channel field
  logic        code_rsv;                     // reserved mode code
  logic        start_det;                    // start bit accepted
  logic        start_ok;                     // start bits may be heard
  logic [4:0]  read_min;                     // bits out before next start
  logic        sample_now;                   // sample instant this cycle

  // mode, power and channel configuration
  amcs_mode_e  mode_reg;                     // conversion method
  amcs_pwr_e   pwr_reg;                      // analog power state
  logic [2:0]  chan_reg;                     // channel of this conversion
  logic [3:0]  range_mem [N_CH];             // per-channel range code

  // two-entry result buffer
  logic [15:0] buf_mem [2];                  // entries
  logic        wr_ptr_reg;                   // write index
  logic        rd_ptr_reg;                   // read index
  logic [1:0]  cnt_reg;                      // entries held
  logic [1:0]  cnt_next;                     // entries after this cycle
  logic        push;                         // core hands a word
  logic        pop;                          // shifter takes a word

  // result shifter
  logic [15:0] sh_reg;                       // result being shifted out
  logic        pend_reg;                     // unread result present
  logic [4:0]  out_cnt_reg;                  // bits shifted out
  logic        strobe_reg;                   // conversion done strobe
  logic        to_extclk;                    // byte now selecting serial-clock mode
  logic        armed_reg;                    // rise seen since load or last shift
  logic        sample_reg;                   // sample pulse
  logic        step_reg;                     // conversion step pulse
  logic [3:0]  range_reg;                    // range of sampled channel
  logic        dout_reg;                     // serial data out
  logic        oe_reg;                       // data out enable
  logic        ready_reg;                    // buffer has room

  // two flops before any logic sees a pin
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync1_reg <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      sync2_reg <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      sync3_reg <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
    end
    else
    begin
      sync1_reg <= pins_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign sclk_rise = sync2_reg.sclk & ~sync3_reg.sclk;
  assign sclk_fall = ~sync2_reg.sclk & sync3_reg.sclk;
  assign cs_low    = ~sync2_reg.cs_n;

  // byte fields, usable when the seed reaches the top
  assign byte_done = (state_reg == ST_CMD) && rx_reg[START_POS];
  assign rx_tag    = rx_reg[TAG_HI:TAG_LO];
  assign rx_code   = amcs_mode_e'(rx_reg[CODE_HI:CODE_LO]);
  assign code_rsv  = (rx_code == MODE_RSV3) || (rx_code == MODE_RSV5);
  // reset also lands in serial-clock mode, so the strobe must drop with it
  assign to_extclk = byte_done && cs_low && (rx_tag == TAG_MODE)
                     && ((rx_code == MODE_EXTCLK) || (rx_code == MODE_RESET));

  // how much of a pending result must be out first
  always_comb
  begin
    case (mode_reg)
      MODE_EXTACQ: read_min = READ_MIN_EXTACQ;
      MODE_ICLK:   read_min = READ_MIN_ICLK;
      default:     read_min = READ_MIN_EXTCLK;
    endcase
  end

  assign start_ok  = !pend_reg || (out_cnt_reg >= read_min);
  // first high data bit on a rising edge with select low
  assign start_det = (state_reg == ST_IDLE) && cs_low && sclk_rise
                     && sync2_reg.din && start_ok;

  // internal clock runs after the start delay in internal clock mode, and while converting outside serial-clock mode
  assign iclk_tick = (div_cnt_reg == 4'(ICLK_DIV - 1));

  // sample instant for each method
  always_comb
  begin
    sample_now = 1'b0;
    if (state_reg == ST_ACQ && sclk_fall && cs_low)
    begin
      if (mode_reg == MODE_EXTCLK)
        sample_now = (fall_cnt_reg == SAMPLE_FALL_EXTCLK - 5'd1);
      else if (mode_reg == MODE_EXTACQ)
        sample_now = (fall_cnt_reg == SAMPLE_FALL_EXTACQ - 5'd1);
    end
    else if (state_reg == ST_ICLK && iclk_tick)
      sample_now = (tick_cnt_reg == SAMPLE_TICK_ICLK - 4'd1);
  end

  // next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (start_det)
          state_next = ST_CMD;
      ST_CMD:
        // a half byte with select released is dropped
        if (!cs_low)
          state_next = ST_IDLE;
        else if (byte_done)
        begin
          // conversions only start at full power
          if (rx_tag == TAG_CONV && pwr_reg == PWR_FULL)
            state_next = ST_ACQ;
          else
            state_next = ST_IDLE;
        end
      ST_ACQ:
        if (!cs_low)
          state_next = ST_IDLE;
        else if (sample_now)
          state_next = ST_CONV;
        else if (mode_reg == MODE_ICLK && sclk_fall && fall_cnt_reg == ARM_FALL_ICLK - 5'd1)
          state_next = ST_DELAY;
      ST_DELAY:
        if (dly_cnt_reg == 5'(ICLK_START_CYC - 1))
          state_next = ST_ICLK;
      ST_ICLK:
        if (sample_now)
          state_next = ST_CONV;
      ST_CONV:
        // the conversion ends when its word enters the buffer
        if (push)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // receive shifter and serial edge counter
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_reg       <= RX_SEED;
      fall_cnt_reg <= 5'd0;
    end
    else if (start_det)
    begin
      // seed travels up as seven bits follow the start bit
      rx_reg       <= RX_SEED;
      fall_cnt_reg <= 5'd0;
    end
    else
    begin
      if (state_reg == ST_CMD && sclk_rise && !rx_reg[START_POS])
        rx_reg <= {rx_reg[6:0], sync2_reg.din};
      // counter saturates so it never wraps back onto a match
      if ((state_reg == ST_CMD || state_reg == ST_ACQ) && sclk_fall && fall_cnt_reg != 5'h1f)
        fall_cnt_reg <= fall_cnt_reg + 5'd1;
    end
  end

  // internal clock: start delay, divider and tick count
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dly_cnt_reg  <= 5'd0;
      div_cnt_reg  <= 4'd0;
      tick_cnt_reg <= 4'd0;
    end
    else
    begin
      // delay counts only while waiting to start
      if (state_reg == ST_DELAY)
        dly_cnt_reg <= dly_cnt_reg + 5'd1;
      else
        dly_cnt_reg <= 5'd0;
      // divider runs when internally timed work is under way
      if (state_reg == ST_ICLK || (state_reg == ST_CONV && mode_reg != MODE_EXTCLK))
        div_cnt_reg <= iclk_tick ? 4'd0 : div_cnt_reg + 4'd1;
      else
        div_cnt_reg <= 4'd0;
      if (state_reg == ST_ICLK)
      begin
        if (iclk_tick)
          tick_cnt_reg <= tick_cnt_reg + 4'd1;
      end
      else
        tick_cnt_reg <= 4'd0;
    end
  end

  // mode and power decode of a completed mode byte
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mode_reg <= MODE_EXTCLK;
      pwr_reg  <= PWR_FULL;
    end
    else if (byte_done && cs_low && rx_tag == TAG_MODE && !code_rsv)
    begin
      case (rx_code)
        MODE_RESET:
        begin
          mode_reg <= MODE_EXTCLK;
          pwr_reg  <= PWR_FULL;
        end
        MODE_PPD:
          pwr_reg <= PWR_PARTIAL;
        MODE_FPD:
          pwr_reg <= PWR_OFF;
        default:
        begin
          // any conversion mode byte wakes from either power-down
          mode_reg <= rx_code;
          pwr_reg  <= PWR_FULL;
        end
      endcase
    end
  end

  // per-channel ranges and the channel of a conversion start
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < N_CH; i++)
        range_mem[i] <= RANGE_DEFAULT;
      chan_reg <= 3'd0;
    end
    else if (byte_done && cs_low)
    begin
      if (rx_tag == TAG_MODE)
      begin
        if (rx_code == MODE_RESET)
        begin
          for (int i = 0; i < N_CH; i++)
            range_mem[i] <= RANGE_DEFAULT;
        end
      end
      else if (rx_tag == TAG_CONV)
      begin
        // a start refused in power-down keeps the old channel
        if (pwr_reg == PWR_FULL)
          chan_reg <= rx_reg[CODE_HI:CODE_LO];
      end
      else
        range_mem[rx_reg[CODE_HI:CODE_LO]] <= rx_tag;
    end
  end

  // result buffer: the shifter drains it only once the last word is read
  assign push     = result_valid_i && ready_reg;
  assign pop      = (cnt_reg != 2'd0) && !pend_reg;
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      buf_mem[0] <= 16'h0000;
      buf_mem[1] <= 16'h0000;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'd0;
      ready_reg  <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        buf_mem[wr_ptr_reg] <= result_data_i;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg   <= cnt_next;
      // room is judged on the count after this cycle
      ready_reg <= (cnt_next != 2'd2);
    end
  end

  // result shifter, one bit per falling edge while selected
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sh_reg      <= 16'h0000;
      pend_reg    <= 1'b0;
      out_cnt_reg <= 5'd0;
      armed_reg   <= 1'b0;
    end
    else if (pop)
    begin
      sh_reg      <= buf_mem[rd_ptr_reg];
      pend_reg    <= 1'b1;
      out_cnt_reg <= 5'd0;
      armed_reg   <= 1'b0;
    end
    // a fall shifts only after a rise, so a word loaded just before a fall
    // still shows b15 for a whole serial clock period
    else if (pend_reg && cs_low && sclk_rise)
      armed_reg <= 1'b1;
    else if (pend_reg && cs_low && sclk_fall && armed_reg)
    begin
      sh_reg      <= {sh_reg[14:0], 1'b0};
      out_cnt_reg <= out_cnt_reg + 5'd1;
      armed_reg   <= 1'b0;
      if (out_cnt_reg == 5'(RES_W - 1))
        pend_reg <= 1'b0;
    end
  end

  // done strobe: set wins over the start-bit clear, never set in serial-clock mode
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      strobe_reg <= 1'b0;
    else if (mode_reg == MODE_EXTCLK || to_extclk)
      strobe_reg <= 1'b0;
    else if (pop)
      strobe_reg <= 1'b1;
    else if (start_det)
      strobe_reg <= 1'b0;
  end

  // pulses and registered outputs
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sample_reg <= 1'b0;
      step_reg   <= 1'b0;
      range_reg  <= RANGE_DEFAULT;
      dout_reg   <= 1'b0;
      oe_reg     <= 1'b0;
    end
    else
    begin
      sample_reg <= sample_now;
      if (sample_now)
        range_reg <= range_mem[chan_reg];
      // serial clock paces serial-clock mode, the divider the rest
      if (state_reg == ST_CONV)
        step_reg <= (mode_reg == MODE_EXTCLK) ? sclk_fall : iclk_tick;
      else
        step_reg <= 1'b0;
      dout_reg <= pend_reg && sh_reg[RES_W - 1];
      oe_reg   <= cs_low;
    end
  end

  // outputs straight from flops; the strobe ignores chip select
  assign conversion_done_strobe_o = strobe_reg;
  assign dout_o                   = dout_reg;
  assign dout_oe_o                = oe_reg;
  assign sample_o                 = sample_reg;
  assign conv_step_o              = step_reg;
  assign channel_o                = chan_reg;
  assign range_o                  = range_reg;
  assign mode_o                   = mode_reg;
  assign power_o                  = pwr_reg;
  assign result_ready_o           = ready_reg;

endmodule

`default_nettype wire

// ### sim/amcs_sequencer_sva.sv
/*
  amcs_seq_chk: port timing checks of the mode and conversion sequencer.
  assumes: bound to amcs_sequencer, single sys_clk_i domain.
*/
`timescale 1ns/100ps
`default_nettype none

module amcs_seq_chk
  import amcs_pkg::*;
(
  input wire logic                 sys_clk_i,
  input wire logic                 arst_n_i,
  input wire amcs_pkg::amcs_pins_s pins_i,
  input wire logic                 conversion_done_strobe_o,
  input wire logic                 sample_o,
  input wire logic                 conv_step_o,
  input wire amcs_pkg::amcs_mode_e mode_o,
  input wire amcs_pkg::amcs_pwr_e  power_o
);
  import amcs_pkg::*;

  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  ext_no_strobe_a: assert property (mode_o == MODE_EXTCLK |-> !conversion_done_strobe_o)
    else $error("strobe high in serial clock mode");
  mode_legal_a: assert property (mode_o inside {MODE_EXTCLK, MODE_EXTACQ, MODE_ICLK})
    else $error("method holds a non conversion code");
  strobe_rise_a: assert property ($rose(conversion_done_strobe_o) |-> mode_o != MODE_EXTCLK)
    else $error("strobe rose in serial clock mode");
  // clear allowed only two clocks after sclk and din high with select low; a byte selecting serial-clock mode or reset is not allowed for
  strobe_fall_a: assert property ($fell(conversion_done_strobe_o) |->
    $past(pins_i.sclk, 2) && $past(pins_i.din, 2) && !$past(pins_i.cs_n, 2))
    else $error("strobe cleared without a start bit");
  // a select glitch alone must never move mode or power
  mode_src_a: assert property ($changed(mode_o) |-> !$past(pins_i.cs_n, 3))
    else $error("mode changed without a byte");
  power_src_a: assert property ($changed(power_o) |-> !$past(pins_i.cs_n, 3))
    else $error("power changed without a byte");
  sample_full_a: assert property (sample_o |-> power_o == PWR_FULL)
    else $error("sample taken while powered down");
  sample_once_a: assert property (sample_o |=> !sample_o [*4])
    else $error("sample pulse repeated");
  step_after_a: assert property (sample_o |-> ##[1:100] conv_step_o)
    else $error("no conversion step after sample");

  // one sample in each conversion method
  cover property (sample_o && mode_o == MODE_EXTCLK);
  cover property (sample_o && mode_o == MODE_EXTACQ);
  cover property (sample_o && mode_o == MODE_ICLK);
endmodule

bind amcs_sequencer amcs_seq_chk u_chk
(
  .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .pins_i(pins_i), .sample_o(sample_o),
  .conversion_done_strobe_o(conversion_done_strobe_o), .conv_step_o(conv_step_o),
  .mode_o(mode_o), .power_o(power_o)
);

`default_nettype wire

// ### sim/amcs_host.sv
/*
  amcs_host: serial master model, one frame per call of frame().
  assumes: driven from the bench's sys_clk_i, sclk period 8 clocks.
*/
`timescale 1ns/100ps
`default_nettype none

module amcs_host
  import amcs_pkg::*;
(
  input  wire logic               sys_clk_i,
  input  wire logic               dout_i,
  output var amcs_pkg::amcs_pins_s pins_o
);
  import amcs_pkg::*;

  // link idle: select high, clock parked low
  initial pins_o = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};

  // steady 4/4 clock, select low for every cycle of the frame
  task automatic frame(input logic [7:0] tx, input int n, output logic [47:0] rx);
    rx = '0;
    @(posedge sys_clk_i);
    pins_o.cs_n <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      pins_o.din <= (i < 8) ? tx[7 - i] : 1'b0;
      repeat (4) @(posedge sys_clk_i);
      pins_o.sclk <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rx = {rx[46:0], dout_i};
      pins_o.sclk <= 1'b0;
    end
    // select rises only after the last fall, then pins idle
    repeat (4) @(posedge sys_clk_i);
    pins_o.cs_n <= 1'b1;
    pins_o.din  <= 1'b0;
  endtask
endmodule

`default_nettype wire

// ### sim/tb_amcs_sequencer.sv
/*
  tb_amcs_sequencer: mode table, three conversion methods, readback.
  assumes: amcs_host drives the pins, a small core model answers steps.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_amcs_sequencer;
  import amcs_pkg::*;

  logic               sys_clk_i = 1'b0;
  logic               arst_n_i = 1'b0;
  amcs_pins_s         pins;
  logic               dout, oe, oe_at, strobe, sample, step, rvalid, rready;
  logic [2:0]         ch;
  logic [3:0]         rng;
  amcs_mode_e         mode;
  amcs_pwr_e          pwr;
  logic [15:0]        rdata, exp_w;
  logic [47:0]        rx;
  logic               prev_sclk = 1'b0;
  int                 n_fail, check_count, cyc, nfall, since_fall, fall_at, gap_at, n_samp, nstep;
  // mode byte codes with the {mode, power} expected after each
  localparam logic [2:0] CODE[8] = '{3'h6, 3'h3, 3'h7, 3'h5, 3'h6, 3'h1, 3'h2, 3'h4};
  localparam logic [4:0] EXPV[8] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h01, 5'h04, 5'h08, 5'h00};
  localparam int LO = ICLK_START_CYC + 10 * ICLK_DIV;
  localparam int HI = ICLK_START_MAX_NS / 25 + 11 * ICLK_DIV;
  // reference settling after power-down, scaled far down for the bench
  localparam int SETTLE = 40;

  initial forever #12.5 sys_clk_i = ~sys_clk_i;

  amcs_host u_host (.sys_clk_i(sys_clk_i), .dout_i(dout), .pins_o(pins));

  amcs_sequencer DUT
  (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .pins_i(pins), .dout_o(dout),
    .dout_oe_o(oe), .conversion_done_strobe_o(strobe), .sample_o(sample),
    .conv_step_o(step), .channel_o(ch), .range_o(rng), .mode_o(mode), .power_o(pwr),
    .result_data_i(rdata), .result_valid_i(rvalid), .result_ready_o(rready)
  );

  // core model: a word after 16 steps, next word differs
  always @(posedge sys_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      nstep  <= 0;
      rvalid <= 1'b0;
      rdata  <= 16'ha5c3;
    end
    else
    begin
      if (step)
        nstep <= nstep + 1;
      if (nstep == 16)
      begin
        rvalid <= 1'b1;
        nstep  <= 0;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        rdata  <= rdata + 16'h1111;
      end
    end

  // pin falls since select fell, and clocks since the last fall
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
    prev_sclk  <= pins.sclk;
    since_fall <= (prev_sclk && !pins.sclk) ? 0 : since_fall + 1;
    nfall <= pins.cs_n ? 0 : nfall + int'(prev_sclk && !pins.sclk);
    if (sample)
    begin
      fall_at = nfall;
      gap_at  = since_fall;
      oe_at   = oe;
      n_samp++;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for the done strobe
  task automatic wait_strobe();
    for (int i = 0; i < 2000 && strobe !== 1'b1; i++)
      @(posedge sys_clk_i);
    check(strobe, 1'b1);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    exp_w = 16'ha5c3;
    repeat (2) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    check({mode, pwr, rng, rready, strobe, oe}, {MODE_EXTCLK, PWR_FULL, RANGE_DEFAULT, 3'b100});
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      u_host.frame({1'b1, CODE[i], TAG_MODE}, 8, rx);
      check({mode, pwr}, EXPV[i]);
      // conversion starts refused while powered down
      if (i == 1 || i == 3)
      begin
        u_host.frame(8'hb0, 48, rx);
        check(n_samp, 0);
      end
    end
    $display("test mode table done");
    repeat (SETTLE) @(posedge sys_clk_i);
    u_host.frame(8'hb0, 48, rx);
    check(fall_at, 14);
    check({ch, rng}, {3'h3, RANGE_DEFAULT});
    // word lands just before fall 31, so b15 is first seen at fall 32
    check(rx[16:1], exp_w);
    check(oe_at, 1'b1);
    exp_w += 16'h1111;
    $display("test serial clock conversion done");
    u_host.frame(8'h98, 8, rx);
    u_host.frame(8'hb0, 16, rx);
    // the sample pulse is logged on the very edge the frame ends
    repeat (2) @(posedge sys_clk_i);
    check(fall_at, 16);
    wait_strobe();
    u_host.frame(8'h00, 16, rx);
    check(rx[15:0], exp_w);
    check(strobe, 1'b1);
    u_host.frame(8'ha8, 8, rx);
    check(strobe, 1'b0);
    exp_w += 16'h1111;
    $display("test acquisition conversion done");
    u_host.frame(8'hb0, 8, rx);
    wait_strobe();
    check(gap_at >= LO && gap_at <= HI, 1'b1);
    u_host.frame(8'h00, 16, rx);
    check(rx[15:0], exp_w);
    $display("test internal clock conversion done");
    test_done();
  end
endmodule

`default_nettype wire
